// ---- hdl/cdp_top.sv ----
// cdp_top: input clock divider, duty cycle stabilizer lock, divider sync and
// power-down / standby control, with an APB register slave.
// assumes clk is the sample clock, sync_pin and power_down_pin are synchronous.
//
// Overview of operation
// [RULE1] The sample clock is divided by a programmable integer ratio from one to eight.
// [RULE2] Software must enable the stabilizer for ratios three, five, six, seven and eight.
// [RULE3] Two bits of the sync register choose realign on every pulse or only on the first after a write.
// [RULE4] An accepted sync pulse returns the divider counter to its initial state.
// [RULE5] The sync input passes a synchronizer on the sample clock before acting on the divider.
// [RULE6] With the stabilizer on, the internal clock is high for half the divided period; the code rounds odd ratios down and stays high at ratio one.
// [RULE7] Below the minimum input rate the stabilizer stays off and timing follows the raw input.
// [RULE8] After a clock change the stabilizer relocks within 1.5 to 5 us and is bypassed until then.
// [RULE9] Power-down is entered when the power mode field selects it or the power-down pin is high.
// [RULE10] While powered down the serial drivers are released and the internal clock stops.
// [RULE11] Leaving power-down needs a recharge time before conversions are valid again.
// [RULE12] Standby keeps the reference on and the serial outputs running for a faster wake-up.
// [RULE13] In first-pulse mode further sync pulses are ignored until the sync register is written again.
//
// Design decisions made here: the register offsets and the APB slave port.
`timescale 1ns/1ps
`include "cdp_defs.svh"

module cdp_top
   import cdp_pkg::*;
#(
   parameter int CLK_KHZ  = `CDP_CLK_KHZ,
   parameter int LOCK_CYC = (`CDP_DCS_LOCK_NS * 1000 + `CDP_CLK_PERIOD_PS - 1) / `CDP_CLK_PERIOD_PS,
   parameter int CHG_CYC  = (`CDP_RECHARGE_NS * 1000 + `CDP_CLK_PERIOD_PS - 1) / `CDP_CLK_PERIOD_PS
) (
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        sync_pin,
   input  wire logic        power_down_pin,
   output logic             conv_clk,
   output logic             sample_strobe,
   output logic             conv_valid,
   output logic             ser_oe,
   output logic             ref_en,
   output logic             dcs_locked
);

   localparam int LW = $clog2(LOCK_CYC + 1);
   localparam int CW = $clog2(CHG_CYC + 1);
   localparam logic [LW-1:0] LOCK_END = LW'(LOCK_CYC);
   localparam logic [CW-1:0] CHG_END  = CW'(CHG_CYC - 1);
   localparam logic DCS_CAPABLE = (CLK_KHZ >= `CDP_DCS_MIN_KHZ);

   // register state
   logic [1:0]  pmode;
   logic [1:0]  sync_cfg;
   logic [3:0]  div_cfg;
   logic [1:0]  next_pmode;
   logic [1:0]  next_sync_cfg;
   logic [3:0]  next_div_cfg;
   logic [31:0] next_prdata;
   logic        next_pready;
   logic        next_pslverr;
   logic        wr_en;
   logic        sel_pwr;
   logic        sel_sync;
   logic        sel_div;
   logic        sel_stat;
   logic        ratio_wr;

   // sync state
   logic        sync_s1;
   logic        sync_s2;
   logic        sync_s3;
   logic        sync_armed;
   logic        next_sync_armed;
   logic        sync_rise;
   logic        sync_acc;

   // divider state
   logic [2:0]  cnt;
   logic [2:0]  next_cnt;
   logic [3:0]  ratio;
   logic [3:0]  hi_len;
   logic        dcs_active;
   logic        run;
   logic        next_conv_clk;
   logic        next_strobe;

   // stabilizer lock and power state
   logic [LW-1:0] lock_cnt;
   logic [LW-1:0] next_lock_cnt;
   logic          next_dcs_locked;
   logic [CW-1:0] chg_cnt;
   logic [CW-1:0] next_chg_cnt;
   cdp_pwr_t      pstate;
   cdp_pwr_t      next_pstate;
   logic          pd_req;
   logic          stby_req;

   // apb decode, register writes and read answer
   always_comb begin
      sel_pwr  = 1'b0;
      sel_sync = 1'b0;
      sel_div  = 1'b0;
      sel_stat = 1'b0;
      if (paddr[1:0] != 2'h0 || paddr[11:10] != 2'h0) begin
         sel_pwr = 1'b0;
      end else if (paddr[9:2] == `CDP_IDX_PWR) begin
         sel_pwr = 1'b1;
      end else if (paddr[9:2] == `CDP_IDX_SYNC) begin
         sel_sync = 1'b1;
      end else if (paddr[9:2] == `CDP_IDX_DIV) begin
         sel_div = 1'b1;
      end else if (paddr[9:2] == `CDP_IDX_STAT) begin
         sel_stat = 1'b1;
      end
      wr_en         = psel && penable && pready && pwrite;
      ratio_wr      = wr_en && sel_div && (pwdata[2:0] != div_cfg[2:0]);
      next_pmode    = (wr_en && sel_pwr)  ? pwdata[1:0] : pmode;
      next_sync_cfg = (wr_en && sel_sync) ? pwdata[`CDP_SYNC_ONCE_BIT:`CDP_SYNC_EN_BIT] : sync_cfg; // RULE3
      next_div_cfg  = (wr_en && sel_div)  ? pwdata[3:0] : div_cfg;
      next_pready   = psel && penable && !pready;
      next_pslverr  = next_pready && !(sel_pwr || sel_sync || sel_div || sel_stat);
      next_prdata   = 32'h0;
      if (next_pready && !pwrite) begin
         if (sel_pwr) begin
            next_prdata = {30'h0, pmode};
         end else if (sel_sync) begin
            next_prdata = {29'h0, sync_cfg, 1'b0};
         end else if (sel_div) begin
            next_prdata = {28'h0, div_cfg};
         end else if (sel_stat) begin
            next_prdata = {26'h0, DCS_CAPABLE, conv_valid, pstate == pwr_stby,
                           pstate == pwr_down, sync_armed, dcs_locked};
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pmode    <= `CDP_PWR_RST;
         sync_cfg <= `CDP_SYNC_RST;
         div_cfg  <= `CDP_DIV_RST;
         prdata   <= 32'h0;
         pready   <= 1'b0;
         pslverr  <= 1'b0;
      end else begin
         pmode    <= next_pmode;
         sync_cfg <= next_sync_cfg;
         div_cfg  <= next_div_cfg;
         prdata   <= next_prdata;
         pready   <= next_pready;
         pslverr  <= next_pslverr;
      end
   end

   // sync synchronizer, edge detect and first-pulse arming
   always_comb begin
      sync_rise = sync_s2 && !sync_s3;                                     // RULE5
      sync_acc  = sync_cfg[0] && sync_rise && run && (!sync_cfg[1] || sync_armed); // RULE3
      next_sync_armed = sync_armed;
      if (wr_en && sel_sync) begin
         next_sync_armed = 1'b1;                    // write rearms, wins over a pulse
      end else if (sync_acc && sync_cfg[1]) begin
         next_sync_armed = 1'b0;                    // RULE13
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sync_s1    <= 1'b0;
         sync_s2    <= 1'b0;
         sync_s3    <= 1'b0;
         sync_armed <= 1'b1;
      end else begin
         sync_s1    <= sync_pin;                    // RULE5
         sync_s2    <= sync_s1;
         sync_s3    <= sync_s2;
         sync_armed <= next_sync_armed;
      end
   end

   // divider counter and divided clock shaping
   always_comb begin
      run        = (pstate == pwr_run) || (pstate == pwr_wake);  // RULE10
      ratio      = {1'b0, div_cfg[2:0]} + 4'h1;                  // RULE1
      dcs_active = div_cfg[`CDP_DIV_DCS_BIT] && dcs_locked;      // RULE8
      hi_len     = dcs_active ? (ratio >> 1) : 4'h1;             // RULE6
      if (hi_len == 4'h0) begin
         hi_len = 4'h1;
      end
      if (!run || sync_acc) begin
         next_cnt = 3'h0;                                        // RULE4
      end else if (cnt == div_cfg[2:0]) begin
         next_cnt = 3'h0;                                        // RULE1
      end else begin
         next_cnt = cnt + 3'h1;
      end
      next_conv_clk = run && ({1'b0, next_cnt} < hi_len);
      next_strobe   = run && (next_cnt == 3'h0);
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cnt           <= 3'h0;
         conv_clk      <= 1'b0;
         sample_strobe <= 1'b0;
      end else begin
         cnt           <= next_cnt;
         conv_clk      <= next_conv_clk;
         sample_strobe <= next_strobe;
      end
   end

   // stabilizer lock timer, restarted by any clock change
   always_comb begin
      if (!DCS_CAPABLE || !div_cfg[`CDP_DIV_DCS_BIT] || ratio_wr || pstate == pwr_down) begin
         next_lock_cnt = '0;                                     // RULE7 RULE8
      end else if (lock_cnt != LOCK_END) begin
         next_lock_cnt = lock_cnt + 1'b1;
      end else begin
         next_lock_cnt = lock_cnt;
      end
      next_dcs_locked = (next_lock_cnt == LOCK_END);             // RULE8
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         lock_cnt   <= '0;
         dcs_locked <= 1'b0;
      end else begin
         lock_cnt   <= next_lock_cnt;
         dcs_locked <= next_dcs_locked;
      end
   end

   // power state machine and pad / reference controls
   always_comb begin
      pd_req       = power_down_pin || (pmode == `CDP_PMODE_DOWN); // RULE9
      stby_req     = (pmode == `CDP_PMODE_STBY);
      next_pstate  = pstate;
      next_chg_cnt = '0;
      case (pstate)
         pwr_run: begin
            if (pd_req) begin
               next_pstate = pwr_down;
            end else if (stby_req) begin
               next_pstate = pwr_stby;
            end
         end
         pwr_stby: begin
            if (pd_req) begin
               next_pstate = pwr_down;
            end else if (!stby_req) begin
               next_pstate = pwr_run;                          // RULE12
            end
         end
         pwr_down: begin
            if (!pd_req) begin
               next_pstate = pwr_wake;                         // RULE11
            end
         end
         pwr_wake: begin
            next_chg_cnt = chg_cnt + 1'b1;
            if (pd_req) begin
               next_pstate = pwr_down;
            end else if (chg_cnt == CHG_END) begin
               next_pstate = stby_req ? pwr_stby : pwr_run;    // RULE11
            end
         end
         default: begin
            next_pstate = pwr_down;
         end
      endcase
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pstate     <= pwr_run;
         chg_cnt    <= '0;
         ser_oe     <= 1'b0;
         ref_en     <= 1'b0;
         conv_valid <= 1'b0;
      end else begin
         pstate     <= next_pstate;
         chg_cnt    <= next_chg_cnt;
         ser_oe     <= (next_pstate != pwr_down);              // RULE10 RULE12
         ref_en     <= (next_pstate != pwr_down);              // RULE12
         conv_valid <= (next_pstate == pwr_run);               // RULE11
      end
   end

   // helper for checks: cycles between strobes with no realign in between
   logic [3:0] gap;
   logic       gap_ok;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         gap    <= 4'h0;
         gap_ok <= 1'b0;
      end else begin
         gap    <= sample_strobe ? 4'h1 : gap + 4'h1;
         gap_ok <= (gap_ok || sample_strobe) && run && !sync_acc && !(wr_en && sel_div);
      end
   end

   // helper for checks: cycles since power-down was left, saturating
   logic [CW:0] since_down;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         since_down <= '1;
      end else if (pstate == pwr_down) begin
         since_down <= '0;
      end else if (since_down != '1) begin
         since_down <= since_down + 1'b1;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   sequence s_pd_asked;
      pd_req && pstate != pwr_down;
   endsequence
   sequence s_pd_released;
      pstate == pwr_down ##1 !pd_req;
   endsequence

   a_div_period: assert property (sample_strobe && gap_ok |-> gap == ratio) // RULE1
      else $error("divided period differs from ratio");
   a_sync_align: assert property (sync_acc |=> sample_strobe && cnt == 3'h0) // RULE4
      else $error("sync did not realign divider");
   a_sync_delay: assert property (sync_acc |-> $past(sync_pin, 2) && !$past(sync_pin, 3)) // RULE5
      else $error("sync acted without two-stage delay");
   a_sync_once: assert property (sync_acc && sync_cfg[1] && !(wr_en && sel_sync) |=> !sync_armed) // RULE13
      else $error("first-pulse mode stayed armed");
   a_pd_enter: assert property (s_pd_asked |=> pstate == pwr_down && !ser_oe && !ref_en) // RULE9
      else $error("power-down not entered");
   a_pd_clock: assert property (pstate == pwr_down |=> !conv_clk && !sample_strobe) // RULE10
      else $error("internal clock ran in power-down");
   a_pd_wake: assert property (s_pd_released |=> !conv_valid) // RULE11
      else $error("conversions valid on leaving power-down");
   a_wake_time: assert property ($rose(conv_valid) |-> since_down >= CHG_CYC) // RULE11
      else $error("conversions valid before recharge");
   a_stby_keep: assert property (pstate == pwr_stby && stby_req && !pd_req |=> ser_oe && ref_en && !conv_valid) // RULE12
      else $error("standby dropped reference or outputs");
   a_dcs_relock: assert property (ratio_wr |=> !dcs_locked [*8]) // RULE8
      else $error("stabilizer not bypassed after change");
   a_dcs_duty: assert property (sample_strobe && dcs_active && ratio == 4'h8 |-> conv_clk ##4 !conv_clk) // RULE6
      else $error("stabilized clock not half high");

endmodule : cdp_top

// ---- pkg/cdp_defs.svh ----
// cdp_defs.svh: register indices, field positions, reset values and times
// for the clock divider, sync and power control block.
// assumes a 125 MHz sample clock and APB with one 32-bit word per register.
`ifndef CDP_DEFS_SVH
`define CDP_DEFS_SVH

// register indices; byte address is four times the index
`define CDP_IDX_PWR        8'h08
`define CDP_IDX_SYNC       8'h3a
`define CDP_IDX_DIV        8'h0b
`define CDP_IDX_STAT       8'h0c

// field positions
`define CDP_SYNC_EN_BIT    1
`define CDP_SYNC_ONCE_BIT  2
`define CDP_DIV_DCS_BIT    3

// power mode field encodings
`define CDP_PMODE_NORMAL   2'h0
`define CDP_PMODE_DOWN     2'h1
`define CDP_PMODE_STBY     2'h2

// reset values
`define CDP_PWR_RST        2'h0
`define CDP_SYNC_RST       2'h0
`define CDP_DIV_RST        4'h8

// times
`define CDP_CLK_PERIOD_PS  8000
`define CDP_DCS_LOCK_NS    1500
`define CDP_RECHARGE_NS    1000
`define CDP_DCS_MIN_KHZ    20000
`define CDP_CLK_KHZ        125000

`endif

// ---- pkg/cdp_pkg.sv ----
// cdp_pkg: types shared by the clock divider, sync and power control block.
// assumes nothing beyond a SystemVerilog elaborator.
package cdp_pkg;

   // power state of the converter clocking
   typedef enum logic [1:0] {
      pwr_run,
      pwr_stby,
      pwr_down,
      pwr_wake
   } cdp_pwr_t;

endpackage : cdp_pkg

// ---- bench/cdp_sync_src.sv ----
// cdp_sync_src: sample clock side model that issues divider sync pulses.
// assumes fire is a one-cycle request from the bench, driven after a rising edge.
`timescale 1ns/1ps

module cdp_sync_src (
   input  wire logic clk,
   input  wire logic rst,
   input  wire logic fire,
   output logic      sync_pin
);
   logic [1:0] hold_cnt;
   logic [1:0] next_hold_cnt;

   // pulse high two cycles, then low so that pulses stay apart
   always_comb begin
      next_hold_cnt = hold_cnt;
      if (fire) begin
         next_hold_cnt = 2'h2;
      end else if (hold_cnt != 2'h0) begin
         next_hold_cnt = hold_cnt - 2'h1;
      end
   end

   // launched just after a rising edge, aligned to the sample clock
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         hold_cnt <= 2'h0;
      end else begin
         hold_cnt <= next_hold_cnt;
      end
   end

   assign sync_pin = (hold_cnt != 2'h0); // driven low between pulses
endmodule : cdp_sync_src

// ---- bench/tb.sv ----
// tb: self-checking bench for cdp_top over apb, power pin and sync source.
// assumes cdp_defs.svh on the include path and the cdp_sync_src model.
`timescale 1ns/1ps
`include "cdp_defs.svh"

module tb;
   localparam int          CHG    = 4;
   localparam logic [11:0] A_PWR  = {2'b00, `CDP_IDX_PWR, 2'b00};
   localparam logic [11:0] A_SYNC = {2'b00, `CDP_IDX_SYNC, 2'b00};
   localparam logic [11:0] A_DIV  = {2'b00, `CDP_IDX_DIV, 2'b00};
   localparam logic [11:0] A_STAT = {2'b00, `CDP_IDX_STAT, 2'b00};
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic        power_down_pin = 1'b0;
   logic        fire = 1'b0;
   logic [31:0] prdata;
   logic        pready, pslverr, sync_pin, conv_clk, sample_strobe;
   logic        conv_valid, ser_oe, ref_en, dcs_locked;
   logic [31:0] rd, er;
   int          err_total = 0;
   int          check_count = 0;
   int          n;

   always #4 clk = ~clk;

   cdp_top #(.LOCK_CYC(8), .CHG_CYC(CHG)) dut (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .sync_pin(sync_pin), .power_down_pin(power_down_pin), .conv_clk(conv_clk), .sample_strobe(sample_strobe),
      .conv_valid(conv_valid), .ser_oe(ser_oe), .ref_en(ref_en), .dcs_locked(dcs_locked));

   cdp_sync_src src (.clk(clk), .rst(rst), .fire(fire), .sync_pin(sync_pin));

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : print_verdict

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         err_total++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   // one apb transfer, held until pready, then one idle edge
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int i;
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clk);
      penable <= 1'b1;
      for (i = 0; i < 16; i++) begin
         @(posedge clk);
         if (pready === 1'b1) break;
      end
      if (i == 16) begin
         err_total++;
         print_verdict();
      end
      rd = prdata;
      er = 32'(pslverr);
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask : apb

   // bounded wait for a watched output: 0 strobe, 1 lock, 2 valid, 3 sync pin
   task automatic wait_for(input int s, output int c);
      logic v;
      for (c = 0; c < 300; c++) begin
         @(posedge clk);
         v = (s == 0) ? sample_strobe : (s == 1) ? dcs_locked : (s == 2) ? conv_valid : sync_pin;
         if (v === 1'b1) break;
      end
      if (c == 300) begin
         err_total++;
         print_verdict();
      end
   endtask : wait_for

   task automatic high_run(input logic [31:0] exp);
      int c;
      wait_for(0, n);
      for (c = 0; c < 20 && conv_clk === 1'b1; c++) begin
         @(posedge clk);
      end
      chk(c, exp);
   endtask : high_run

   // one sync pulse, strobe looked at three edges after the pin is seen
   task automatic sync_try(input logic [31:0] exp);
      fire <= 1'b1;
      @(posedge clk);
      fire <= 1'b0;
      wait_for(3, n);
      repeat (3) @(posedge clk);
      chk(32'(sample_strobe), exp);
   endtask : sync_try

   // main sequence
   initial begin
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      apb(1'b0, A_DIV, 32'h0);
      chk(rd, 32'h8);
      apb(1'b0, A_PWR, 32'h0);
      chk(rd, 32'h0);
      apb(1'b0, A_SYNC, 32'h0);
      chk(rd, 32'h0);
      apb(1'b0, 12'h004, 32'h0);
      chk({er[0], rd[30:0]}, 32'h80000000);
      apb(1'b1, A_STAT, 32'hffffffff);
      chk(er, 32'h0);
      apb(1'b0, A_STAT, 32'h0);
      chk(rd & 32'h31, 32'h31);
      $display("test registers done");
      for (int r = 1; r <= 8; r++) begin
         apb(1'b1, A_DIV, 32'h8 | 32'(r - 1));
         wait_for(0, n);
         wait_for(0, n);
         wait_for(0, n);
         chk(n + 1, r);
      end
      $display("test divide ratios done");
      apb(1'b1, A_DIV, 32'h7);
      @(posedge clk);
      chk(32'(dcs_locked), 32'h0);
      high_run(32'h1);
      apb(1'b1, A_DIV, 32'he);
      @(posedge clk);
      chk(32'(dcs_locked), 32'h0);
      wait_for(1, n);
      chk(32'(n > 2 && n < 12), 32'h1);
      high_run(32'h3);
      $display("test stabilizer done");
      apb(1'b1, A_SYNC, 32'h2);
      sync_try(32'h1);
      sync_try(32'h1);
      apb(1'b1, A_SYNC, 32'h6);
      sync_try(32'h1);
      sync_try(32'h0);
      apb(1'b1, A_SYNC, 32'h6);
      @(posedge clk);
      sync_try(32'h1);
      $display("test sync done");
      power_down_pin <= 1'b1;
      repeat (4) @(posedge clk);
      chk({ser_oe, ref_en, conv_valid, conv_clk}, 32'h0);
      power_down_pin <= 1'b0;
      wait_for(2, n);
      chk(32'(n >= CHG), 32'h1);
      chk({ser_oe, ref_en}, 32'h3);
      apb(1'b1, A_PWR, 32'h1);
      repeat (2) @(posedge clk);
      chk({ser_oe, ref_en, conv_valid}, 32'h0);
      apb(1'b0, A_STAT, 32'h0);
      chk(rd & 32'h14, 32'h4);
      apb(1'b1, A_PWR, 32'h0);
      wait_for(2, n);
      apb(1'b1, A_PWR, 32'h2);
      repeat (2) @(posedge clk);
      chk({ser_oe, ref_en, conv_valid}, 32'h6);
      apb(1'b0, A_STAT, 32'h0);
      chk(rd & 32'h1c, 32'h8);
      apb(1'b1, A_PWR, 32'h0);
      wait_for(2, n);
      $display("test power done");
      print_verdict();
   end
endmodule : tb
